// file: ecq_pkg.sv
package ecq_pkg;

  // ****************************************************************
  // Widths and types
  // ****************************************************************
  localparam int CNT_W = 14;
  typedef logic [7:0] ecq_byte_type;
  typedef logic [CNT_W-1:0] ecq_cnt_type;
  typedef logic [5:0] ecq_pos_type;
  typedef enum logic [1:0] {
    ST_DATA = 2'b00,
    ST_PAD  = 2'b01,
    ST_FCS  = 2'b10,
    ST_DROP = 2'b11
  } ecq_state_type;

  // ****************************************************************
  // Transmit configuration word bit positions
  // ****************************************************************
  localparam int CFG_W = 32;
  localparam int CFG_VLAN_EN_BIT = 27;
  localparam int CFG_FCS_PASS_BIT = 29;
  localparam int CFG_JUMBO_BIT = 30;

  // ****************************************************************
  // Header field values
  // ****************************************************************
  localparam logic [15:0] VLAN_TPID = 16'h8100;
  localparam logic [15:0] TYPE_IPV4 = 16'h0800;
  localparam logic [15:0] SNAP_LEN_MAX = 16'h0600;
  localparam ecq_byte_type SNAP_SAP = 8'hAA;
  localparam ecq_byte_type SNAP_CTRL = 8'h03;
  localparam ecq_byte_type SNAP_ZERO = 8'h00;
  localparam ecq_byte_type SNAP_TYPE_HI = 8'h08;
  localparam logic [3:0] IP_VER = 4'h4;
  localparam logic [3:0] IP_IHL = 4'h5;
  localparam int IP_MF_BIT = 5;
  localparam ecq_byte_type PROTO_TCP = 8'h06;
  localparam ecq_byte_type PROTO_UDP = 8'h11;

  // ****************************************************************
  // Header byte positions
  // ****************************************************************
  localparam ecq_pos_type POS_LT = 6'h0d;
  localparam ecq_pos_type POS_MAX = 6'h3f;
  localparam ecq_pos_type VLAN_SHIFT = 6'h04;
  localparam ecq_pos_type SNAP_SHIFT = 6'h08;
  localparam ecq_pos_type IP_REL_VER = 6'h00;
  localparam ecq_pos_type IP_REL_FLAGS = 6'h06;
  localparam ecq_pos_type IP_REL_FRAG_LO = 6'h07;
  localparam ecq_pos_type IP_REL_PROTO = 6'h09;
  localparam ecq_cnt_type FRM_POS_TPID_HI = 14'h000c;
  localparam ecq_cnt_type FRM_POS_TPID_LO = 14'h000d;

  // ****************************************************************
  // Frame lengths in bytes, and the index of the last FCS byte
  // ****************************************************************
  localparam ecq_cnt_type HDR_LEN = 14'h000e;
  localparam ecq_cnt_type MIN_DATA_LEN = 14'h002e;
  localparam ecq_cnt_type MIN_FRAME_LEN = HDR_LEN + MIN_DATA_LEN;
  localparam ecq_cnt_type MAX_UNTAG_LEN = 14'h05ee;
  localparam ecq_cnt_type MAX_TAG_LEN = 14'h05f2;
  localparam ecq_cnt_type JUMBO_MAX_LEN = 14'h3fff;
  localparam ecq_cnt_type FCS_LEN = 14'h0004;
  localparam logic [1:0] FCS_LAST = 2'h3;

  // ****************************************************************
  // Frame check sequence
  // ****************************************************************
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

endpackage

// file: ecq_hdr_parse.sv
`timescale 1ns/1ps
module ecq_hdr_parse (
  input wire logic clk,
  input wire logic rst,
  input wire logic byteVal,
  input wire ecq_pkg::ecq_byte_type byteData,
  input wire logic byteLast,
  input wire logic csumAllow,
  output logic qualValid,
  output logic ipCsumEn,
  output logic tcpCsumEn,
  output logic udpCsumEn
);
  import ecq_pkg::*;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  ecq_pos_type pos_r;
  ecq_pos_type ipBase_r;
  ecq_byte_type prev_r;
  logic vlan_r, snap_r, ok_r, done_r;
  logic qual_r, ip_r, tcp_r, udp_r;
  ecq_byte_type snapExp;

  wire [15:0] word = {prev_r, byteData};
  wire ecq_pos_type ltPos = vlan_r ? POS_LT + VLAN_SHIFT : POS_LT;
  wire atTpid = !vlan_r && pos_r == POS_LT && word == VLAN_TPID;
  wire atLt = pos_r == ltPos && !atTpid;
  wire isIpType = word == TYPE_IPV4;
  wire isSnapLen = word <= SNAP_LEN_MAX;
  wire ecq_pos_type ipBaseNxt = ltPos + 6'h01 + (isIpType ? 6'h00 : SNAP_SHIFT);
  wire ecq_pos_type snapRel = pos_r - ltPos - 6'h01;
  wire inSnap = snap_r && pos_r > ltPos && pos_r < ipBase_r;
  wire inIp = ipBase_r != 6'h00 && pos_r >= ipBase_r;
  wire ecq_pos_type ipRel = pos_r - ipBase_r;

  // A second tag lands in the type slot and fails the type test.
  always_comb begin
    case (snapRel[2:0])
      3'h0, 3'h1: snapExp = SNAP_SAP;
      3'h2: snapExp = SNAP_CTRL;
      3'h6: snapExp = SNAP_TYPE_HI;
      default: snapExp = SNAP_ZERO;
    endcase
  end

  wire badLt = atLt && !isIpType && !isSnapLen;
  wire badSnap = inSnap && byteData != snapExp;
  wire badVer = inIp && ipRel == IP_REL_VER && byteData != {IP_VER, IP_IHL};
  wire badFlag = inIp && ipRel == IP_REL_FLAGS && (byteData[IP_MF_BIT] || byteData[4:0] != 5'h00);
  wire badFrag = inIp && ipRel == IP_REL_FRAG_LO && byteData != 8'h00;
  wire fieldOk = ok_r && !badLt && !badSnap && !badVer && !badFlag && !badFrag;
  wire atProto = inIp && ipRel == IP_REL_PROTO;
  wire decide = byteVal && !done_r && (atProto || byteLast);
  wire ipGood = fieldOk && atProto && csumAllow;

  // ****************************************************************
  // State
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_r <= 6'h00;
      ipBase_r <= 6'h00;
      prev_r <= 8'h00;
      vlan_r <= 1'b0;
      snap_r <= 1'b0;
      ok_r <= 1'b1;
      done_r <= 1'b0;
      qual_r <= 1'b0;
      ip_r <= 1'b0;
      tcp_r <= 1'b0;
      udp_r <= 1'b0;
    end else begin
      qual_r <= decide;
      if (decide) begin
        ip_r <= ipGood;
        tcp_r <= ipGood && byteData == PROTO_TCP;
        udp_r <= ipGood && byteData == PROTO_UDP;
      end
      if (byteVal && byteLast) begin
        pos_r <= 6'h00;
        ipBase_r <= 6'h00;
        vlan_r <= 1'b0;
        snap_r <= 1'b0;
        ok_r <= 1'b1;
        done_r <= 1'b0;
      end else if (byteVal) begin
        pos_r <= (pos_r == POS_MAX) ? pos_r : pos_r + 6'h01;
        prev_r <= byteData;
        ok_r <= fieldOk;
        done_r <= done_r || decide;
        vlan_r <= vlan_r || atTpid;
        if (atLt) begin
          snap_r <= !isIpType;
          ipBase_r <= ipBaseNxt;
        end
      end
    end
  end

  assign qualValid = qual_r;
  assign ipCsumEn = ip_r;
  assign tcpCsumEn = tcp_r;
  assign udpCsumEn = udp_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tcp_needs_ip;
    qualValid && tcpCsumEn |-> ipCsumEn && !udpCsumEn;
  endproperty
  a_tcp_needs_ip: assert property (p_tcp_needs_ip) else $error("tcp without ip");

  property p_udp_needs_ip;
    qualValid && udpCsumEn |-> ipCsumEn && $past(byteData) == PROTO_UDP;
  endproperty
  a_udp_needs_ip: assert property (p_udp_needs_ip) else $error("udp qualify wrong");

  property p_ip_only;
    qualValid && $past(byteData) != PROTO_TCP && $past(byteData) != PROTO_UDP
      |-> !tcpCsumEn && !udpCsumEn;
  endproperty
  a_ip_only: assert property (p_ip_only) else $error("transport set for other protocol");

  property p_ip_needs_fields;
    qualValid && ipCsumEn |-> $past(ok_r) && $past(inIp);
  endproperty
  a_ip_needs_fields: assert property (p_ip_needs_fields) else $error("ip qualified badly");

endmodule

// file: ecq_tx_frame.sv
`timescale 1ns/1ps
module ecq_tx_frame (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ecq_pkg::CFG_W-1:0] txConfigReg,
  input wire ecq_pkg::ecq_byte_type s_axis_tdata,
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic s_axis_tlast,
  output ecq_pkg::ecq_byte_type m_axis_tdata,
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic m_axis_tlast,
  output logic m_axis_tuser,
  output logic qualValid,
  output logic ipCsumEn,
  output logic tcpCsumEn,
  output logic udpCsumEn,
  output ecq_pkg::ecq_cnt_type rptLen,
  output logic rptLenValid
);
  import ecq_pkg::*;

  // ****************************************************************
  // Frame check sequence update
  // ****************************************************************
  function automatic logic [31:0] crcNext(input logic [31:0] c, input ecq_byte_type d);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  ecq_state_type st_r, st_nxt;
  ecq_cnt_type cnt_r, cnt_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic [1:0] fcsIdx_r;
  ecq_byte_type b12_r;
  logic passMode_r, jumbo_r, vlanEn_r, tagged_r, errSticky_r, dropAfter_r;
  ecq_byte_type outData_r;
  logic outValid_r, outLast_r, outErr_r;
  ecq_cnt_type rptLen_r;
  logic rptLenValid_r;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // The configuration word is a register on this clock, so it is used
  // without a synchroniser; it is latched per frame so that a change in
  // mid-frame cannot split one frame between two modes.
  wire adv = !outValid_r || m_axis_tready;
  wire inAcc = s_axis_tvalid && s_axis_tready;
  wire frameStart = st_r == ST_DATA && cnt_r == 14'h0000;
  wire modePass = frameStart ? txConfigReg[CFG_FCS_PASS_BIT] : passMode_r;
  wire modeJumbo = frameStart ? txConfigReg[CFG_JUMBO_BIT] : jumbo_r;
  wire modeVlan = frameStart ? txConfigReg[CFG_VLAN_EN_BIT] : vlanEn_r;
  wire ecq_cnt_type cntInc = cnt_r + 14'h0001;
  wire isTagWord = cnt_r == FRM_POS_TPID_LO && {b12_r, s_axis_tdata} == VLAN_TPID;
  wire vlanBad = inAcc && st_r == ST_DATA && isTagWord && !modeVlan;
  wire ecq_cnt_type legalMax = (tagged_r && modeVlan) ? MAX_TAG_LEN : MAX_UNTAG_LEN;
  wire ecq_cnt_type maxLen = modeJumbo ? JUMBO_MAX_LEN : legalMax;
  wire ecq_cnt_type dataLim = modePass ? maxLen : maxLen - FCS_LEN;
  // The byte that reaches the limit without being last proves oversize,
  // so truncation needs no lookahead buffer.
  wire oversize = inAcc && st_r == ST_DATA && !s_axis_tlast && cntInc == dataLim;
  wire errNow = errSticky_r || vlanBad || oversize;
  wire needPad = cntInc < MIN_FRAME_LEN;
  wire dataStep = (st_r == ST_DATA && inAcc) || (st_r == ST_PAD && adv);
  wire fcsStep = st_r == ST_FCS && adv;
  wire loadOut = adv && ((st_r == ST_DATA && s_axis_tvalid) || st_r == ST_PAD || fcsStep);
  wire ecq_byte_type dataIn = (st_r == ST_DATA) ? s_axis_tdata :
                              (st_r == ST_PAD) ? 8'h00 : ~crc_r[7:0];
  wire lastNow = (st_r == ST_FCS) ? fcsIdx_r == FCS_LAST :
                 (st_r == ST_DATA && modePass && (s_axis_tlast || oversize));
  wire frameEnd = loadOut && lastNow;
  wire errOut = (st_r == ST_DATA) ? errNow : errSticky_r;

  assign s_axis_tready = (st_r == ST_DATA && adv) || st_r == ST_DROP;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_DATA: begin
        if (oversize) begin
          st_nxt = modePass ? ST_DROP : ST_FCS;
        end else if (inAcc && s_axis_tlast && !modePass) begin
          st_nxt = needPad ? ST_PAD : ST_FCS;
        end
      end
      ST_PAD: begin
        if (adv && cntInc == MIN_FRAME_LEN) begin
          st_nxt = ST_FCS;
        end
      end
      ST_FCS: begin
        if (fcsStep && fcsIdx_r == FCS_LAST) begin
          st_nxt = dropAfter_r ? ST_DROP : ST_DATA;
        end
      end
      ST_DROP: begin
        if (s_axis_tvalid && s_axis_tlast) begin
          st_nxt = ST_DATA;
        end
      end
      default: st_nxt = ST_DATA;
    endcase
  end

  assign cnt_nxt = frameEnd ? 14'h0000 : (dataStep ? cntInc : cnt_r);
  assign crc_nxt = frameEnd ? CRC_INIT :
                   dataStep ? crcNext(crc_r, dataIn) :
                   fcsStep ? {8'h00, crc_r[31:8]} : crc_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_DATA;
      cnt_r <= 14'h0000;
      crc_r <= CRC_INIT;
      fcsIdx_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      crc_r <= crc_nxt;
      fcsIdx_r <= fcsStep ? fcsIdx_r + 2'h1 : fcsIdx_r;
    end
  end

  // ****************************************************************
  // Per-frame flags
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      passMode_r <= 1'b0;
      jumbo_r <= 1'b0;
      vlanEn_r <= 1'b0;
      b12_r <= 8'h00;
      tagged_r <= 1'b0;
      errSticky_r <= 1'b0;
      dropAfter_r <= 1'b0;
    end else begin
      if (inAcc && frameStart) begin
        passMode_r <= txConfigReg[CFG_FCS_PASS_BIT];
        jumbo_r <= txConfigReg[CFG_JUMBO_BIT];
        vlanEn_r <= txConfigReg[CFG_VLAN_EN_BIT];
      end
      if (inAcc && cnt_r == FRM_POS_TPID_HI) begin
        b12_r <= s_axis_tdata;
      end
      tagged_r <= frameEnd ? 1'b0 : tagged_r || (inAcc && st_r == ST_DATA && isTagWord);
      errSticky_r <= frameEnd ? 1'b0 : errSticky_r || (inAcc && st_r == ST_DATA && errNow);
      dropAfter_r <= (fcsStep && fcsIdx_r == FCS_LAST) ? 1'b0 : dropAfter_r || (oversize && !modePass);
    end
  end

  // ****************************************************************
  // Output stage and length report
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outValid_r <= 1'b0;
      outData_r <= 8'h00;
      outLast_r <= 1'b0;
      outErr_r <= 1'b0;
      rptLen_r <= 14'h0000;
      rptLenValid_r <= 1'b0;
    end else begin
      if (adv) begin
        outValid_r <= loadOut;
        outData_r <= dataIn;
        outLast_r <= lastNow;
        outErr_r <= errOut;
      end
      rptLenValid_r <= frameEnd;
      if (frameEnd) begin
        rptLen_r <= (st_r == ST_FCS) ? cnt_r : cntInc - FCS_LEN;
      end
    end
  end

  assign m_axis_tdata = outData_r;
  assign m_axis_tvalid = outValid_r;
  assign m_axis_tlast = outLast_r;
  assign m_axis_tuser = outErr_r;
  assign rptLen = rptLen_r;
  assign rptLenValid = rptLenValid_r;

  // ****************************************************************
  // Header qualification
  // ****************************************************************
  // Offload is withheld in pass-through mode, since a source FCS would
  // go stale once a checksum is written into the frame.
  ecq_hdr_parse u_parse (
    .clk(clk),
    .rst(rst),
    .byteVal(inAcc),
    .byteData(s_axis_tdata),
    .byteLast(s_axis_tlast),
    .csumAllow(!passMode_r),
    .qualValid(qualValid),
    .ipCsumEn(ipCsumEn),
    .tcpCsumEn(tcpCsumEn),
    .udpCsumEn(udpCsumEn)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  ecq_cnt_type emCnt_r;
  logic emTag_r;
  wire mHs = m_axis_tvalid && m_axis_tready;

  // The framing tag flag clears as the last byte is loaded, so the line side
  // keeps its own copy until that byte has actually left.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emCnt_r <= 14'h0000;
      emTag_r <= 1'b0;
    end else begin
      if (mHs) begin
        emCnt_r <= m_axis_tlast ? 14'h0000 : emCnt_r + 14'h0001;
      end
      emTag_r <= (mHs && m_axis_tlast) ? 1'b0 : emTag_r || tagged_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pad_zero;
    st_r == ST_PAD && adv |=> m_axis_tvalid && m_axis_tdata == 8'h00;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("pad byte not zero");

  property p_pad_entry;
    st_r == ST_DATA && inAcc && s_axis_tlast && !modePass && needPad |=> st_r == ST_PAD;
  endproperty
  a_pad_entry: assert property (p_pad_entry) else $error("short frame not padded");

  property p_rpt_min;
    rptLenValid |-> $past(st_r) != ST_FCS || rptLen >= MIN_FRAME_LEN;
  endproperty
  a_rpt_min: assert property (p_rpt_min) else $error("padded length below minimum");

  property p_pass_last;
    st_r == ST_DATA && inAcc && s_axis_tlast && modePass
      |=> st_r == ST_DATA && m_axis_tvalid && m_axis_tlast;
  endproperty
  a_pass_last: assert property (p_pass_last) else $error("pass-through frame altered");

  property p_vlan_block;
    mHs && m_axis_tlast && emTag_r && !vlanEn_r |-> m_axis_tuser;
  endproperty
  a_vlan_block: assert property (p_vlan_block) else $error("tag sent while disabled");

  property p_max_untag;
    mHs && m_axis_tlast && !jumbo_r && !(emTag_r && vlanEn_r) |-> emCnt_r < MAX_UNTAG_LEN;
  endproperty
  a_max_untag: assert property (p_max_untag) else $error("untagged frame too long");

  property p_trunc;
    oversize && !modeJumbo && modePass |=> m_axis_tlast && m_axis_tuser && st_r == ST_DROP;
  endproperty
  a_trunc: assert property (p_trunc) else $error("oversize not truncated");

  property p_jumbo_cap;
    mHs && m_axis_tlast |-> emCnt_r < JUMBO_MAX_LEN;
  endproperty
  a_jumbo_cap: assert property (p_jumbo_cap) else $error("frame beyond jumbo limit");

  property p_offload_fcs;
    qualValid && ipCsumEn |-> !$past(passMode_r);
  endproperty
  a_offload_fcs: assert property (p_offload_fcs) else $error("offload with source fcs");

  c_tcp: cover property (qualValid && tcpCsumEn);
  c_udp: cover property (qualValid && udpCsumEn);
  c_pad: cover property (st_r == ST_PAD ##1 st_r == ST_FCS);
  c_trunc: cover property (oversize);

endmodule

// file: ecq_dma_src.sv
`timescale 1ns/1ps
// ****************************************************************
// Frame source model
// ****************************************************************
module ecq_dma_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic tready,
  output ecq_pkg::ecq_byte_type tdata,
  output logic tvalid,
  output logic tlast
);
  import ecq_pkg::*;
  ecq_byte_type mem [0:2047];
  logic took;
  initial begin
    tdata = 8'h00;
    tvalid = 1'b0;
    tlast = 1'b0;
  end
  // Judged at the edge itself, so the combinational ready never races this driver.
  always @(posedge clk or posedge rst) took <= !rst && tvalid && tready;
  task automatic send(input int n);
    int i;
    i = 0;
    while (i < n) begin
      @(negedge clk);
      if (tvalid && took) i++;
      if (tvalid && !took) continue;
      if (i < n && !(slow && $urandom_range(1) == 1)) begin
        tdata = mem[i];
        tlast = (i == n - 1);
        tvalid = 1'b1;
      end else begin
        tvalid = 1'b0;
        tlast = 1'b0;
        tdata = ~tdata; // Released data toggles, so a stale byte cannot pass.
      end
    end
  endtask
endmodule

// file: eth_checksum_qualify_tx_framing_bench.sv
`timescale 1ns/1ps
module eth_checksum_qualify_tx_framing_bench;
  import ecq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic stallEn = 1'b0;
  logic mReady = 1'b1;
  logic [CFG_W-1:0] txConfigReg = 32'h0800_0000;
  ecq_byte_type sData;
  ecq_byte_type mData;
  logic sValid, sReady, sLast, mValid, mLast, mUser, qv, ipEn, tcpEn, udpEn, lenV;
  ecq_cnt_type rptLen;
  ecq_cnt_type lenSeen;
  ecq_byte_type outQ [$];
  logic gotLast, lastUser;
  logic [2:0] qSeen;
  int qCnt;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] cfgT [6] = '{32'h0800_0000, 32'h2800_0000, 32'h2800_0000, 32'h0800_0000,
    32'h4800_0000, 32'h0000_0000};
  int nT [6] = '{1515, 1519, 1518, 1518, 2000, 80};
  always #10 clk = ~clk;
  ecq_dma_src src (.clk(clk), .rst(rst), .slow(slow), .tready(sReady), .tdata(sData),
    .tvalid(sValid), .tlast(sLast));
  ecq_tx_frame uut (.clk(clk), .rst(rst), .txConfigReg(txConfigReg), .s_axis_tdata(sData),
    .s_axis_tvalid(sValid), .s_axis_tready(sReady), .s_axis_tlast(sLast),
    .m_axis_tdata(mData), .m_axis_tvalid(mValid), .m_axis_tready(mReady),
    .m_axis_tlast(mLast), .m_axis_tuser(mUser), .qualValid(qv), .ipCsumEn(ipEn),
    .tcpCsumEn(tcpEn), .udpCsumEn(udpEn), .rptLen(rptLen), .rptLenValid(lenV));
  // ****************************************************************
  // Line side sink and monitor
  // ****************************************************************
  always @(negedge clk) mReady <= stallEn ? 1'($urandom_range(1)) : 1'b1;
  always @(posedge clk) begin
    if (mValid && mReady) begin
      outQ.push_back(mData);
      gotLast = mLast;
      lastUser = mUser;
    end
    if (qv) begin
      qSeen = {ipEn, tcpEn, udpEn};
      qCnt++;
    end
    if (lenV) lenSeen = rptLen;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [31:0] crc_of(input int m, input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < m; i++) begin
      c ^= {24'h00_0000, i < n ? src.mem[i] : 8'h00};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction
  function automatic logic [2:0] qual_exp(input int n, input logic pass);
    int p;
    logic ok;
    p = 12;
    ok = !pass;
    if ({src.mem[p], src.mem[p+1]} == 16'h8100) p = p + 4;
    if ({src.mem[p], src.mem[p+1]} <= 16'h0600) begin
      ok = ok && {src.mem[p+2], src.mem[p+3], src.mem[p+4]} == 24'hAA_AA03;
      ok = ok && {src.mem[p+5], src.mem[p+6], src.mem[p+7]} == 24'h00_0000;
      p = p + 8;
    end
    ok = ok && {src.mem[p], src.mem[p+1]} == 16'h0800 && n > p + 11;
    p = p + 2;
    ok = ok && src.mem[p] == 8'h45 && src.mem[p+6][5:0] == 6'h00 && src.mem[p+7] == 8'h00;
    return {ok, ok && src.mem[p+9] == 8'h06, ok && src.mem[p+9] == 8'h11};
  endfunction
  task automatic put(inout int p, input logic [63:0] v, input int nb);
    for (int i = 0; i < nb; i++) src.mem[p+i] = 8'(v >> (8 * (nb - 1 - i)));
    p = p + nb;
  endtask
  task automatic build(input int n, input int vlan, input int snap, input int fault,
    input ecq_byte_type proto);
    int p = 12;
    for (int i = 0; i < n; i++) src.mem[i] = 8'($urandom);
    if (vlan) put(p, (fault == 1 ? 64'h9100_0000 : 64'h8100_0000) | 64'(16'($urandom)), 4);
    if (vlan && fault == 9) put(p, 64'h8100_0000, 4);
    if (snap) put(p, fault == 2 ? 64'h0601 : 64'h0600, 2);
    put(p, (snap ? 64'hAAAA_0300_0000_0800 : 64'h0800) ^ (fault == 3 ?
      64'h0000_0100_0000_0000 : fault == 8 ? 64'h1 : 64'h0), snap ? 8 : 2);
    src.mem[p] = fault == 4 ? 8'h65 : fault == 5 ? 8'h46 : 8'h45;
    src.mem[p+6] = {2'($urandom), fault == 6, 5'h00};
    src.mem[p+7] = fault == 7 ? 8'h01 : 8'h00;
    src.mem[p+9] = proto;
  endtask
  task automatic run(input int n, input logic [31:0] cfg);
    int lim, m, k;
    logic pass, tag, err;
    logic [2:0] qe;
    @(negedge clk);
    txConfigReg = cfg;
    pass = cfg[CFG_FCS_PASS_BIT];
    tag = {src.mem[12], src.mem[13]} == 16'h8100;
    lim = cfg[CFG_JUMBO_BIT] ? 16383 : (tag && cfg[CFG_VLAN_EN_BIT]) ? 1522 : 1518;
    lim = pass ? lim : lim - 4;
    err = n > lim || (tag && !cfg[CFG_VLAN_EN_BIT]);
    m = n > lim ? lim : (!pass && n < 60) ? 60 : n;
    qe = qual_exp(n, pass);
    outQ = {};
    gotLast = 1'b0;
    lastUser = 1'bx;
    lenSeen = 14'h3fff;
    qCnt = 0;
    src.send(n);
    for (k = 0; k < 300 && !gotLast; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    check(outQ.size(), m + (pass ? 0 : 4), "byte count");
    check(lastUser, err, "error marker");
    check(qCnt, 1, "result count");
    check(qSeen, qe, "checksum enables");
    if (!err) begin
      for (k = 0; k < m; k++) check(outQ[k], k < n ? src.mem[k] : 8'h00, "byte");
      if (!pass) check({outQ[m+3], outQ[m+2], outQ[m+1], outQ[m]}, crc_of(m, n), "fcs");
      check(lenSeen, pass ? n - 4 : m, "reported length");
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    void'($urandom(69));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    build(20, 0, 0, 0, 8'h06);
    run(20, 32'h0800_0000);
    for (int f = 0; f < 48; f++) begin
      slow = 1'($urandom);
      stallEn = 1'($urandom);
      n = (f % 5 == 4) ? $urandom_range(100, 64) : $urandom_range(100, 40);
      build(n, f % 2, (f / 2) % 2, (f / 4) % 10, (f % 3 == 0) ? 8'h06 : (f % 3 == 1) ?
        8'h11 : 8'h01);
      run(n, (f % 5 == 4) ? 32'h2800_0000 : 32'h0800_0000);
    end
    slow = 1'b0;
    stallEn = 1'b0;
    for (int t = 0; t < 6; t++) begin
      build(nT[t], t == 3 || t == 5, 0, (t == 5) ? 8 : 0, 8'h11);
      run(nT[t], cfgT[t]);
    end
    close_out();
  end
  // A hang ends the run well past the roughly fifteen thousand cycles the tests need.
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
